// >>> design/pbf_pkg.sv
/*
 * Shared constants for the pre-bias, filter and snapshot command bank:
 * command indices, byte counts, field positions, reset values, timing.
 * Assumes a 10 MHz system clock and a 32-bit APB register bus.
 */
package pbf_pkg;

    // ------------------------------------------------------------
    // bus shape and command indices
    // ------------------------------------------------------------
    localparam int PADDR_W = 10;
    localparam logic [7:0] CMD_SLEW = 8'hd4;
    localparam logic [7:0] CMD_FILTER = 8'hd5;
    localparam logic [7:0] CMD_SNAPSHOT = 8'hd7;
    localparam logic [7:0] CMD_THERMAL = 8'hd8;
    // byte address is four times the command index
    localparam logic [PADDR_W-1:0] ADDR_SLEW = {CMD_SLEW, 2'b00};
    localparam logic [PADDR_W-1:0] ADDR_FILTER = {CMD_FILTER, 2'b00};
    localparam logic [PADDR_W-1:0] ADDR_SNAPSHOT = {CMD_SNAPSHOT, 2'b00};
    localparam logic [PADDR_W-1:0] ADDR_THERMAL = {CMD_THERMAL, 2'b00};

    // ------------------------------------------------------------
    // block lengths in bytes
    // ------------------------------------------------------------
    localparam logic [5:0] SLEW_BYTES = 6'h08;
    localparam logic [5:0] SNAP_BYTES = 6'h20;
    localparam logic [5:0] THERM_BYTES = 6'h08;

    // ------------------------------------------------------------
    // field positions (lsb) and reset values
    // ------------------------------------------------------------
    localparam int SLEW_VIN_POS = 48;
    localparam int SLEW_VIN_NEG = 32;
    localparam int SLEW_VOUT_POS = 16;
    localparam int SLEW_VOUT_NEG = 0;
    localparam logic [63:0] SLEW_RESET = 64'h7fff_7fff_7fff_7fff;
    localparam logic [7:0] FILTER_RESET = 8'h00;
    localparam logic [7:0] FILT_VOUT = 8'h00;
    localparam logic [7:0] FILT_IOUT = 8'h01;
    localparam logic [7:0] FILT_INPUT_FEED_FORWARD = 8'h02;

    localparam int SNAP_CYCLES = 240;
    localparam int SNAP_FAULTS = 232;
    localparam int SNAP_ST_OTHER = 224;
    localparam int SNAP_ST_CML = 216;
    localparam int SNAP_ST_TEMP = 208;
    localparam int SNAP_ST_VIN = 200;
    localparam int SNAP_ST_IOUT = 192;
    localparam int SNAP_ST_VOUT = 184;
    localparam int SNAP_ST_BYTE = 176;
    localparam int SNAP_ST_WORD = 160;
    localparam int SNAP_TIME = 144;
    localparam int SNAP_TEMP2 = 128;
    localparam int SNAP_TEMP1 = 112;
    localparam int SNAP_IOUT = 96;
    localparam int SNAP_VOUT = 80;
    localparam int SNAP_VIN = 64;
    localparam int SNAP_DUTY_OLD = 48;
    localparam int SNAP_IOUT_OLD = 32;
    localparam int SNAP_VOUT_OLD = 16;
    localparam int SNAP_VIN_OLD = 0;
    localparam logic [255:0] SNAP_RESET = {256{1'b1}};

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PBF_NVM_IDLE = 2'b01,
        PBF_NVM_WRITE = 2'b10
    } pbf_nvm_state_t;

endpackage

// >>> design/pbf_cmd_bank.sv
/*
 * Command register bank of a converter controller: pre-bias slew
 * limits, filter coefficient select, power-loss snapshot record and a
 * read-only thermal compensation block, reached over APB.
 * Assumes all monitor inputs come from logic on clk, and that the
 * non-volatile store accepts one byte per cycle with nvmWrReady high.
 */
// Our own choice: register access over APB.
`timescale 1ns/1ns
module pbf_cmd_bank #(
    parameter int SECOND_CYCLES = pbf_pkg::SECOND_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pbf_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // slope monitors, signed V/ms
    input wire logic signed [15:0] vinSlope,
    input wire logic signed [15:0] voutSlope,
    output logic prebiasStartOk,
    // filter selection
    output logic [2:0] filterSetSel,
    // converter state
    input wire logic vinPresent,
    input wire logic converterRunning,
    input wire logic outputOn,
    input wire logic faultEvent,
    // live measurements and status
    input wire logic [7:0] statusOther,
    input wire logic [7:0] statusCml,
    input wire logic [7:0] statusTemp,
    input wire logic [7:0] statusVin,
    input wire logic [7:0] statusIout,
    input wire logic [7:0] statusVout,
    input wire logic [7:0] statusByte,
    input wire logic [15:0] statusWord,
    input wire logic [15:0] tempSensorA,
    input wire logic [15:0] tempSensorB,
    input wire logic sensorSelB,
    input wire logic [15:0] loadCurrent,
    input wire logic [15:0] outputVoltage,
    input wire logic [15:0] inputVoltage,
    input wire logic [15:0] dutyOld,
    input wire logic [15:0] loadCurrentOld,
    input wire logic [15:0] outputVoltageOld,
    input wire logic [15:0] inputVoltageOld,
    // thermal compensation parameters held elsewhere
    input wire logic [63:0] thermalParams,
    // non-volatile store write port
    output logic nvmWrValid,
    output logic [4:0] nvmWrAddr,
    output logic [7:0] nvmWrData,
    input wire logic nvmWrReady,
    output logic snapshotBusy
);
    import pbf_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [63:0] slewLimits, slewShadow;
    logic [7:0] filterSelect, rdByte, faultCount;
    logic [255:0] snapRecord, next_record;
    logic [PADDR_W-1:0] blkAddr;
    logic [5:0] blkPos, curPos, curCount, dataIdx;
    logic isBlock, mapped, readOnly, access;
    logic vinPrev, outPrev, rampedUp, cmdOff, capture;
    logic [15:0] shutdownCount, secondsCount;
    logic [31:0] tickCount;
    pbf_nvm_state_t nvmState;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    always_comb begin
        isBlock = 1'b0;
        mapped = 1'b1;
        readOnly = 1'b0;
        curCount = 6'h00;
        if (paddr == ADDR_SLEW) begin
            isBlock = 1'b1;
            curCount = SLEW_BYTES;
        end else if (paddr == ADDR_FILTER) begin
            isBlock = 1'b0;
        end else if (paddr == ADDR_SNAPSHOT) begin
            isBlock = 1'b1;
            readOnly = 1'b1;
            curCount = SNAP_BYTES;
        end else if (paddr == ADDR_THERMAL) begin
            isBlock = 1'b1;
            readOnly = 1'b1;
            curCount = THERM_BYTES;
        end else begin
            mapped = 1'b0;
        end
    end

    // a block restarts at its count byte whenever another block address is accessed without error
    assign curPos = (paddr == blkAddr) ? blkPos : 6'h00;
    assign dataIdx = curPos - 6'h01; // six bits keep the top byte in range
    assign access = psel && penable;
    // one wait-free access phase; prdata is loaded in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && readOnly));

    // ------------------------------------------------------------
    // read byte selection
    // ------------------------------------------------------------
    always_comb begin
        rdByte = 8'h00;
        if (paddr == ADDR_FILTER) begin
            rdByte = filterSelect;
        end else if (isBlock && curPos == 6'h00) begin
            rdByte = {2'b00, curCount};
        end else if (paddr == ADDR_SLEW) begin
            rdByte = slewLimits[8*dataIdx[2:0] +: 8];
        end else if (paddr == ADDR_SNAPSHOT) begin
            rdByte = snapRecord[8*dataIdx[4:0] +: 8];
        end else if (paddr == ADDR_THERMAL) begin
            rdByte = thermalParams[8*dataIdx[2:0] +: 8];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rdByte};
        end
    end

    // ------------------------------------------------------------
    // block pointer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            blkAddr <= '0;
            blkPos <= 6'h00;
        end else if (access && mapped && isBlock && !pslverr) begin
            blkAddr <= paddr;
            // wraps to the count byte after the last data byte
            blkPos <= (curPos == curCount) ? 6'h00 : curPos + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    // the limits change only when the eighth byte lands, so a torn
    // block write never gates a start with half-old limits
    always_ff @(posedge clk) begin
        if (srst) begin
            slewShadow <= SLEW_RESET;
            slewLimits <= SLEW_RESET;
        end else if (access && pwrite && paddr == ADDR_SLEW
                     && curPos != 6'h00) begin
            slewShadow[8*dataIdx[2:0] +: 8] <= pwdata[7:0];
            if (curPos == SLEW_BYTES) begin
                slewLimits <= {pwdata[7:0], slewShadow[55:0]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            filterSelect <= FILTER_RESET;
        end else if (access && pwrite && paddr == ADDR_FILTER) begin
            filterSelect <= pwdata[7:0];
        end
    end

    // one-hot coefficient set; an undefined code selects none
    always_ff @(posedge clk) begin
        if (srst) begin
            filterSetSel <= 3'b001;
        end else begin
            filterSetSel <= {filterSelect == FILT_INPUT_FEED_FORWARD,
                filterSelect == FILT_IOUT, filterSelect == FILT_VOUT};
        end
    end

    // ------------------------------------------------------------
    // pre-bias slope gate
    // ------------------------------------------------------------
    // falling limits are magnitudes: the negated slope is compared
    always_ff @(posedge clk) begin
        if (srst) begin
            prebiasStartOk <= 1'b0;
        end else begin
            prebiasStartOk <=
                (vinSlope <= $signed(slewLimits[SLEW_VIN_POS +: 16]))
                && (-vinSlope <= $signed(slewLimits[SLEW_VIN_NEG +: 16]))
                && (voutSlope <= $signed(slewLimits[SLEW_VOUT_POS +: 16]))
                && (-voutSlope <= $signed(slewLimits[SLEW_VOUT_NEG +: 16]));
        end
    end

    // ------------------------------------------------------------
    // power cycle bookkeeping
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            vinPrev <= 1'b0;
            outPrev <= 1'b0;
        end else begin
            vinPrev <= vinPresent;
            outPrev <= outputOn;
        end
    end

    // a loss after a commanded off still stores, but as the blank record with only the cycle count filled in
    assign capture = vinPrev && !vinPresent && (converterRunning || cmdOff)
                     && nvmState == PBF_NVM_IDLE;

    always_ff @(posedge clk) begin
        if (srst) begin
            rampedUp <= 1'b0;
            cmdOff <= 1'b0;
        end else if (!vinPresent || (outputOn && !outPrev)) begin
            rampedUp <= outputOn && vinPresent;
            cmdOff <= 1'b0;
        end else if (outPrev && !outputOn && rampedUp) begin
            cmdOff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shutdownCount <= 16'h0000;
        end else if (capture && shutdownCount != 16'hffff) begin
            shutdownCount <= shutdownCount + 16'h0001;
        end
    end

    // event counted in the same cycle as the restart still counts
    always_ff @(posedge clk) begin
        if (srst) begin
            faultCount <= 8'h00;
        end else if (vinPresent && !vinPrev) begin
            faultCount <= {7'h00, faultEvent};
        end else if (faultEvent && faultCount != 8'hff) begin
            faultCount <= faultCount + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tickCount <= 32'h0000_0000;
            secondsCount <= 16'h0000;
        end else if (vinPresent && !vinPrev) begin
            tickCount <= 32'h0000_0000;
            secondsCount <= 16'h0000;
        end else if (vinPresent) begin
            if (tickCount == 32'(SECOND_CYCLES - 1)) begin
                tickCount <= 32'h0000_0000;
                if (secondsCount != 16'hffff) begin
                    secondsCount <= secondsCount + 16'h0001;
                end
            end else begin
                tickCount <= tickCount + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // snapshot record
    // ------------------------------------------------------------
    always_comb begin
        next_record = '0;
        next_record[SNAP_FAULTS +: 8] = faultCount;
        next_record[SNAP_ST_OTHER +: 8] = statusOther;
        next_record[SNAP_ST_CML +: 8] = statusCml;
        next_record[SNAP_ST_TEMP +: 8] = statusTemp;
        next_record[SNAP_ST_VIN +: 8] = statusVin;
        next_record[SNAP_ST_IOUT +: 8] = statusIout;
        next_record[SNAP_ST_VOUT +: 8] = statusVout;
        next_record[SNAP_ST_BYTE +: 8] = statusByte;
        next_record[SNAP_ST_WORD +: 16] = statusWord;
        next_record[SNAP_TIME +: 16] = secondsCount;
        next_record[SNAP_TEMP2 +: 16] =
            sensorSelB ? tempSensorA : tempSensorB;
        next_record[SNAP_TEMP1 +: 16] =
            sensorSelB ? tempSensorB : tempSensorA;
        next_record[SNAP_IOUT +: 16] = loadCurrent;
        next_record[SNAP_VOUT +: 16] = outputVoltage;
        next_record[SNAP_VIN +: 16] = inputVoltage;
        next_record[SNAP_DUTY_OLD +: 16] = dutyOld;
        next_record[SNAP_IOUT_OLD +: 16] = loadCurrentOld;
        next_record[SNAP_VOUT_OLD +: 16] = outputVoltageOld;
        next_record[SNAP_VIN_OLD +: 16] = inputVoltageOld;
        if (cmdOff) begin
            next_record = SNAP_RESET;
        end
        // the counter includes the shutdown being recorded
        next_record[SNAP_CYCLES +: 16] = shutdownCount + 16'h0001;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            snapRecord <= SNAP_RESET;
        end else if (capture) begin
            snapRecord <= next_record;
        end
    end

    // ------------------------------------------------------------
    // nvm writer: 32 bytes, lowest first
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            nvmState <= PBF_NVM_IDLE;
            nvmWrAddr <= 5'h00;
            nvmWrData <= 8'h00;
        end else begin
            case (nvmState)
                PBF_NVM_IDLE: begin
                    if (capture) begin
                        nvmState <= PBF_NVM_WRITE;
                        nvmWrAddr <= 5'h00;
                        nvmWrData <= next_record[7:0];
                    end
                end
                PBF_NVM_WRITE: begin
                    if (nvmWrReady) begin
                        if (nvmWrAddr == 5'h1f) begin
                            nvmState <= PBF_NVM_IDLE;
                        end else begin
                            nvmWrAddr <= nvmWrAddr + 5'h01;
                            nvmWrData <= snapRecord[8*(nvmWrAddr+5'h01) +: 8];
                        end
                    end
                end
                default: begin
                    nvmState <= PBF_NVM_IDLE;
                end
            endcase
        end
    end

    assign nvmWrValid = (nvmState == PBF_NVM_WRITE);
    assign snapshotBusy = (nvmState == PBF_NVM_WRITE);

endmodule

// >>> sim/pbf_checker.sv
/*
 * Port checker for pbf_cmd_bank: bus refusals, filter select shape
 * and the snapshot store write sequence.
 * Assumes it is bound into every pbf_cmd_bank instance.
 */
`timescale 1ns/1ns
module pbf_checker
    import pbf_pkg::*;
#(
    parameter int SECOND_CYCLES = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pbf_pkg::PADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // converter and store
    input wire logic vinPresent,
    input wire logic converterRunning,
    input wire logic [2:0] filterSetSel,
    input wire logic nvmWrValid,
    input wire logic [4:0] nvmWrAddr,
    input wire logic [7:0] nvmWrData,
    input wire logic nvmWrReady,
    input wire logic snapshotBusy
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire acc = psel && penable;

    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    a_snap_ro: assert property (acc && pwrite &&
        paddr == ADDR_SNAPSHOT |-> pslverr) else $error("snapshot written");
    a_therm_ro: assert property (acc && pwrite &&
        paddr == ADDR_THERMAL |-> pslverr) else $error("thermal written");
    a_filter_ok: assert property (acc && paddr == ADDR_FILTER
        |-> !pslverr && pready) else $error("filter access refused");
    a_filter_shape: assert property ($onehot0(filterSetSel))
        else $error("filter select not one-hot");
    a_store_start: assert property ($fell(vinPresent) &&
        converterRunning && !snapshotBusy && !$past(srst)
        |=> nvmWrValid && nvmWrAddr == 5'h00) else $error("no store");
    a_store_cause: assert property ($rose(nvmWrValid) |->
        $past(vinPresent, 2) && !$past(vinPresent)) else $error("bad store");
    a_store_hold: assert property (nvmWrValid && !nvmWrReady
        |=> nvmWrValid && $stable(nvmWrAddr) && $stable(nvmWrData))
        else $error("store byte changed while stalled");
    a_store_step: assert property (nvmWrValid && nvmWrReady &&
        nvmWrAddr != 5'h1f |=> nvmWrValid &&
        nvmWrAddr == $past(nvmWrAddr) + 5'h01) else $error("bad step");
    a_store_end: assert property (nvmWrValid && nvmWrReady &&
        nvmWrAddr == 5'h1f |=> !nvmWrValid) else $error("store overran");
    a_busy_flag: assert property (snapshotBusy == nvmWrValid)
        else $error("busy differs from store valid");

    c_slew_write: cover property (acc && pwrite && paddr == ADDR_SLEW);
    c_store: cover property ($rose(nvmWrValid));
    c_stall: cover property (nvmWrValid && !nvmWrReady);
endmodule

bind pbf_cmd_bank pbf_checker #(.SECOND_CYCLES(SECOND_CYCLES)) i_pbf_checker (
    .clk, .srst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
    .vinPresent, .converterRunning, .filterSetSel, .nvmWrValid,
    .nvmWrAddr, .nvmWrData, .nvmWrReady, .snapshotBusy);

// >>> sim/pbf_nvm_model.sv
/*
 * Behavioural non-volatile store taking snapshot bytes.
 * Assumes one writer on clk; slow makes it stall at random.
 */
`timescale 1ns/1ns
module pbf_nvm_model (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // store write port
    input wire logic nvmWrValid,
    input wire logic [4:0] nvmWrAddr,
    input wire logic [7:0] nvmWrData,
    output logic nvmWrReady,
    // stall control
    input wire logic slow
);
    logic [7:0] mem [32];
    int seed = 31;

    // random stalls make the writer hold the current byte until nvmWrReady is high
    always_ff @(posedge clk) begin
        if (srst) begin
            nvmWrReady <= 1'h0;
        end else begin
            nvmWrReady <= !slow || 1'($random(seed));
        end
    end

    always_ff @(posedge clk) begin
        if (nvmWrValid && nvmWrReady) begin
            mem[nvmWrAddr] <= nvmWrData;
        end
    end
endmodule

// >>> sim/pbf_cmd_bank_tb.sv
/*
 * Self-checking bench for pbf_cmd_bank with the store model.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ns
module pbf_cmd_bank_tb;
    import pbf_pkg::*;
    localparam int SC = 10;
    int seed = 90067;
    int n_errors = 0;
    int checked = 0;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
    logic [PADDR_W-1:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, prebiasStartOk, e;
    logic signed [15:0] vinSlope = 16'h0, voutSlope = 16'h0;
    logic [2:0] filterSetSel;
    logic vinPresent = 1'h0, converterRunning = 1'h0, outputOn = 1'h0;
    logic faultEvent = 1'h0, sensorSelB = 1'h0;
    logic [7:0] st [7];
    logic [15:0] w [10];
    logic [63:0] thermalParams = 64'h0, lim;
    logic nvmWrValid, nvmWrReady, snapshotBusy;
    logic [4:0] nvmWrAddr;
    logic [7:0] nvmWrData, q;
    logic [255:0] v, x;

    pbf_cmd_bank #(.SECOND_CYCLES(SC)) i_pbf_cmd_bank (
        .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .vinSlope, .voutSlope, .prebiasStartOk,
        .filterSetSel, .vinPresent, .converterRunning, .outputOn,
        .faultEvent, .statusOther(st[0]), .statusCml(st[1]),
        .statusTemp(st[2]), .statusVin(st[3]), .statusIout(st[4]),
        .statusVout(st[5]), .statusByte(st[6]), .statusWord(w[0]),
        .tempSensorA(w[1]), .tempSensorB(w[2]), .sensorSelB,
        .loadCurrent(w[3]), .outputVoltage(w[4]), .inputVoltage(w[5]),
        .dutyOld(w[6]), .loadCurrentOld(w[7]), .outputVoltageOld(w[8]),
        .inputVoltageOld(w[9]), .thermalParams, .nvmWrValid, .nvmWrAddr,
        .nvmWrData, .nvmWrReady, .snapshotBusy);
    pbf_nvm_model i_pbf_nvm_model (.clk, .srst, .nvmWrValid, .nvmWrAddr,
        .nvmWrData, .nvmWrReady, .slow);

    always #50 clk = ~clk;

    // ----------------------------------------------------------
    // tasks and expectations
    // ----------------------------------------------------------
    task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one byte per transfer; pready is still waited for, never assumed
    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a,
            input logic [7:0] d, output logic [7:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n == 50) n_errors++;
    endtask

    task automatic blk_rd(input logic [PADDR_W-1:0] a, input int nb,
            output logic [255:0] r);
        logic [7:0] b;
        logic er;
        r = 256'h0;
        apb(1'h0, a, 8'h00, b, er);
        cmp(b, nb);
        for (int i = 0; i < nb; i++) begin
            apb(1'h0, a, 8'h00, b, er);
            r[i*8 +: 8] = b;
        end
    endtask

    task automatic blk_wr(input logic [PADDR_W-1:0] a, input logic [63:0] d);
        logic [7:0] b;
        logic er;
        apb(1'h1, a, 8'h08, b, er);
        for (int i = 0; i < 8; i++) apb(1'h1, a, d[i*8 +: 8], b, er);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (snapshotBusy !== 1'h0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n == 500) n_errors++;
    endtask

    function automatic logic gate_exp(input logic [63:0] l);
        return int'(vinSlope) <= int'($signed(l[63:48])) &&
            -int'(vinSlope) <= int'($signed(l[47:32])) &&
            int'(voutSlope) <= int'($signed(l[31:16])) &&
            -int'(voutSlope) <= int'($signed(l[15:0]));
    endfunction

    function automatic logic [255:0] rec_exp(input logic [7:0] flt,
            input logic [15:0] secs);
        return {16'h0001, flt, st[0], st[1], st[2], st[3], st[4], st[5],
            st[6], w[0], secs, sensorSelB ? w[1] : w[2],
            sensorSelB ? w[2] : w[1], w[3], w[4], w[5], w[6], w[7], w[8],
            w[9]};
    endfunction

    task automatic final_report;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        final_report();
    end

    initial begin
        foreach (st[k]) st[k] = 8'h00;
        foreach (w[k]) w[k] = 16'h0;
        thermalParams = {$random(seed), $random(seed)};
        repeat (8) @(posedge clk);
        srst <= 1'h0;
        apb(1'h0, ADDR_FILTER, 8'h00, q, e);
        cmp(q, FILTER_RESET);
        cmp(filterSetSel, 3'h1);
        blk_rd(ADDR_SLEW, 8, v);
        cmp(v, SLEW_RESET);
        blk_rd(ADDR_THERMAL, 8, v);
        cmp(v, thermalParams);
        blk_rd(ADDR_SNAPSHOT, 32, v);
        cmp(v, SNAP_RESET);
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            apb(1'h1, ADDR_FILTER, 8'(c), q, e);
            apb(1'h0, ADDR_FILTER, 8'h00, q, e);
            cmp(q, c);
            cmp(filterSetSel, c < 3 ? 3'h1 << c : 3'h0);
        end
        apb(1'h1, ADDR_SNAPSHOT, 8'h00, q, e);
        cmp(e, 1'h1);
        apb(1'h1, ADDR_THERMAL, 8'h00, q, e);
        cmp(e, 1'h1);
        $display("filter and refusal test done");
        for (int i = 0; i < 4; i++) lim[i*16 +: 16] = 16'($random(seed) % 1000);
        blk_wr(ADDR_SLEW, lim);
        blk_rd(ADDR_SLEW, 8, v);
        cmp(v, lim);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            vinSlope <= i == 0 ? lim[63:48] : 16'($random(seed) % 1200);
            voutSlope <= i == 0 ? lim[31:16] : 16'($random(seed) % 1200);
            repeat (2) @(posedge clk);
            cmp(prebiasStartOk, gate_exp(lim));
        end
        $display("pre-bias gate test done");
        @(posedge clk);
        foreach (st[k]) st[k] <= 8'($random(seed));
        foreach (w[k]) w[k] <= 16'($random(seed));
        sensorSelB <= 1'($random(seed));
        slow <= 1'h1;
        converterRunning <= 1'h1;
        outputOn <= 1'h1;
        vinPresent <= 1'h1;
        repeat (3) begin
            repeat (4) @(posedge clk);
            faultEvent <= 1'h1;
            @(posedge clk);
            faultEvent <= 1'h0;
        end
        repeat (20) @(posedge clk);
        vinPresent <= 1'h0;
        repeat (2) @(posedge clk);
        cmp(snapshotBusy, 1'h1);
        wait_idle();
        x = rec_exp(8'h03, 16'h0003);
        blk_rd(ADDR_SNAPSHOT, 32, v);
        cmp(v, x);
        for (int i = 0; i < 32; i++) v[i*8 +: 8] = i_pbf_nvm_model.mem[i];
        cmp(v, x);
        $display("power loss test done");
        slow <= 1'h0;
        converterRunning <= 1'h0;
        outputOn <= 1'h0;
        vinPresent <= 1'h1;
        repeat (3) @(posedge clk);
        outputOn <= 1'h1;
        repeat (3) @(posedge clk);
        outputOn <= 1'h0;
        repeat (3) @(posedge clk);
        vinPresent <= 1'h0;
        repeat (2) @(posedge clk);
        wait_idle();
        blk_rd(ADDR_SNAPSHOT, 32, v);
        cmp(v, {16'h0002, {240{1'h1}}});
        $display("commanded off test done");
        final_report();
    end
endmodule
